// *** src/rtv_core.sv ***
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Alarm upper byte: minutes, weekday, month, none
// - Alarm lower byte: seconds, hours, day, none
// - Repeat count gives further alarm repetitions
// - Without chime, count zero means no further repeat
// - Each alarm event while enabled decrements a nonzero repeat count; an alarm config write in the same cycle wins
// - Count stops at zero unless chime wraps
// - Year holds two BCD digits, upper zero
// - Year writes need value write enable
// - Month/day BCD field layout
// - Weekday/hours BCD field layout
// - Hour tens digit limited to two
// - Minutes/seconds BCD field layout
// - Date and alarm writes need write enable
// - Unimplemented value bits read zero
// - Alarm month/day same layout, all writable
// - Window pointer decrements per access, stops zero
// - Alarm enable clears at zero without chime
// - Time pointer selects minutes_seconds_value, weekday_hours_value, month_day_value, year
module rtv_core #(
    parameter int ADDR_W = rtv_pkg::ADDR_W,
    parameter int DATA_W = rtv_pkg::DATA_W,
    parameter int RPT_W  = rtv_pkg::RPT_W
) (
    // Clock and reset
    input  wire logic                             clk_in,
    input  wire logic                             reset_n_in,
    // Register port
    input  wire logic [ADDR_W-1:0]                addr_in,
    input  wire logic [DATA_W-1:0]                wr_data_in,
    input  wire logic                             wr_in,
    input  wire logic                             rd_in,
    output logic      [DATA_W-1:0]                rd_data_out,
    // Calendar and alarm events
    input  wire logic                             month_update_in,
    input  wire logic [rtv_pkg::MONTH_W-1:0]      month_value_in,
    input  wire logic                             alarm_event_in,
    // Alarm state
    output logic                                  alarm_enable_out
);

    localparam int PW = rtv_pkg::PTR_W;

    // Implemented bits of the addressed value register
    function automatic logic [15:0] win_mask(input logic [1:0] ptr,
                                             input logic       alarm,
                                             input logic       for_write);
        logic [15:0] m;
        m = 16'h0000;
        case (ptr)
            rtv_pkg::PTR_MINUTES_SECONDS_VALUE: begin
                m = rtv_pkg::MASK_MINUTES_SECONDS_VALUE;
            end
            rtv_pkg::PTR_WEEKDAY_HOURS_VALUE: begin
                m = rtv_pkg::MASK_WEEKDAY_HOURS_VALUE;
            end
            rtv_pkg::PTR_MONTH_DAY_VALUE: begin
                if (!alarm && for_write) begin
                    m = rtv_pkg::MASK_MONTH_DAY_VALUE_SW;
                end else begin
                    m = rtv_pkg::MASK_MONTH_DAY_VALUE;
                end
            end
            rtv_pkg::PTR_YEAR: begin
                m = alarm ? 16'h0000 : rtv_pkg::MASK_YEAR;
            end
            default: begin
                m = 16'h0000;
            end
        endcase
        return m;
    endfunction : win_mask

    // Clamp the hour tens digit of a weekday/hours word
    function automatic logic [15:0] limit_hours(input logic [15:0] v);
        logic [15:0] r;
        r = v;
        if (v[rtv_pkg::HR_TEN_LSB +: 2] > rtv_pkg::HR_TEN_MAX) begin
            r[rtv_pkg::HR_TEN_LSB +: 2] = rtv_pkg::HR_TEN_MAX;
        end
        return r;
    endfunction : limit_hours

    // Value storage, indexed by window pointer
    logic [15:0]       time_val_ff  [0:3];
    logic [15:0]       alarm_val_ff [0:2];
    logic [15:0]       nxt_time_val [0:3];
    logic [15:0]       nxt_alarm_val[0:2];

    // Control state
    logic              wren_ff;
    logic              nxt_wren;
    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] nxt_rd_data;

    // Decode
    logic              wr_cfg;
    logic              wr_alm_cfg;
    logic              acc_time_win;
    logic              acc_alm_win;
    logic              wr_time_ok;
    logic              wr_alm_ok;
    logic [PW-1:0]     time_ptr;
    logic [PW-1:0]     alarm_ptr;
    logic              alm_chime;
    logic [RPT_W-1:0]  alm_cnt;
    logic              alm_en;
    logic [15:0]       wr_word;

    assign wr_cfg       = wr_in && (addr_in == rtv_pkg::OFS_CFG);
    assign wr_alm_cfg   = wr_in && (addr_in == rtv_pkg::OFS_ALM_CFG);
    assign acc_time_win = (wr_in || rd_in) && (addr_in == rtv_pkg::OFS_TIME_WIN);
    assign acc_alm_win  = (wr_in || rd_in) && (addr_in == rtv_pkg::OFS_ALM_WIN);
    assign wr_time_ok   = wr_in && (addr_in == rtv_pkg::OFS_TIME_WIN) && wren_ff;
    assign wr_alm_ok    = wr_in && (addr_in == rtv_pkg::OFS_ALM_WIN) && wren_ff;
    assign wr_word      = wr_data_in[15:0];

    // Window pointers
    rtv_win_ptr #(
        .PTR_W      (PW)
    ) u_time_ptr (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .load_in    (wr_cfg),
        .load_val_in(wr_data_in[rtv_pkg::PTR_LSB +: PW]),
        .access_in  (acc_time_win),
        .ptr_out    (time_ptr)
    );

    rtv_win_ptr #(
        .PTR_W      (PW)
    ) u_alarm_ptr (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .load_in    (wr_alm_cfg),
        .load_val_in(wr_data_in[rtv_pkg::PTR_LSB +: PW]),
        .access_in  (acc_alm_win),
        .ptr_out    (alarm_ptr)
    );

    // Repeat counter and alarm enable
    rtv_repeat_cnt #(
        .RPT_W      (RPT_W)
    ) u_repeat (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .load_in    (wr_alm_cfg),
        .en_in      (wr_data_in[rtv_pkg::ALM_EN_BIT]),
        .chime_in   (wr_data_in[rtv_pkg::CHIME_BIT]),
        .cnt_in     (wr_data_in[rtv_pkg::RPT_LSB +: RPT_W]),
        .event_in   (alarm_event_in),
        .en_out     (alm_en),
        .chime_out  (alm_chime),
        .cnt_out    (alm_cnt)
    );

    // Value register updates
    always_comb begin
        logic [15:0] m;
        m = win_mask(time_ptr, 1'b0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            nxt_time_val[i] = time_val_ff[i];
        end
        for (int i = 0; i < 3; i++) begin
            nxt_alarm_val[i] = alarm_val_ff[i];
        end
        if (wr_time_ok) begin
            // Only implemented, writable bits change
            nxt_time_val[time_ptr] = (time_val_ff[time_ptr] & ~m) | (wr_word & m);
            if (time_ptr == rtv_pkg::PTR_WEEKDAY_HOURS_VALUE) begin
                nxt_time_val[time_ptr] = limit_hours(nxt_time_val[time_ptr]);
            end
        end
        if (month_update_in) begin
            nxt_time_val[rtv_pkg::PTR_MONTH_DAY_VALUE][rtv_pkg::MONTH_LSB +: rtv_pkg::MONTH_W] =
                month_value_in;
        end
        if (wr_alm_ok && (alarm_ptr != rtv_pkg::PTR_YEAR)) begin
            m = win_mask(alarm_ptr, 1'b1, 1'b1);
            nxt_alarm_val[alarm_ptr[1:0]] = wr_word & m;
            if (alarm_ptr == rtv_pkg::PTR_WEEKDAY_HOURS_VALUE) begin
                nxt_alarm_val[alarm_ptr[1:0]] = limit_hours(wr_word & m);
            end
        end
    end

    // Value registers are undefined after reset
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < 4; i++) begin
            time_val_ff[i] <= nxt_time_val[i];
        end
        for (int i = 0; i < 3; i++) begin
            alarm_val_ff[i] <= nxt_alarm_val[i];
        end
    end

    // Control and read path
    always_comb begin
        logic [15:0] v;
        v           = 16'h0000;
        nxt_wren    = wren_ff;
        nxt_rd_data = '0;
        if (wr_cfg) begin
            nxt_wren = wr_data_in[rtv_pkg::WREN_BIT];
        end
        if (rd_in) begin
            case (addr_in)
                rtv_pkg::OFS_CFG: begin
                    v[rtv_pkg::WREN_BIT]         = wren_ff;
                    v[rtv_pkg::PTR_LSB +: PW]     = time_ptr;
                end
                rtv_pkg::OFS_ALM_CFG: begin
                    v[rtv_pkg::ALM_EN_BIT]        = alm_en;
                    v[rtv_pkg::CHIME_BIT]         = alm_chime;
                    v[rtv_pkg::PTR_LSB +: PW]     = alarm_ptr;
                    v[rtv_pkg::RPT_LSB +: RPT_W]  = alm_cnt;
                end
                rtv_pkg::OFS_TIME_WIN: begin
                    v = time_val_ff[time_ptr] & win_mask(time_ptr, 1'b0, 1'b0);
                end
                rtv_pkg::OFS_ALM_WIN: begin
                    if (alarm_ptr != rtv_pkg::PTR_YEAR) begin
                        v = alarm_val_ff[alarm_ptr[1:0]]
                            & win_mask(alarm_ptr, 1'b1, 1'b0);
                    end
                end
                default: begin
                    v = 16'h0000;
                end
            endcase
            nxt_rd_data = DATA_W'(v);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            wren_ff    <= 1'b0;
            rd_data_ff <= rtv_pkg::RDATA_RST;
        end else begin
            wren_ff    <= nxt_wren;
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data_out      = rd_data_ff;
    assign alarm_enable_out = alm_en;

endmodule : rtv_core

`default_nettype wire

// *** src/rtv_pkg.sv ***
package rtv_pkg;

    // Register port geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int PTR_W  = 2;
    localparam int RPT_W  = 8;

    // Register offsets (word index on the plain register port)
    localparam logic [2:0] OFS_CFG      = 3'h0;
    localparam logic [2:0] OFS_ALM_CFG  = 3'h1;
    localparam logic [2:0] OFS_TIME_WIN = 3'h2;
    localparam logic [2:0] OFS_ALM_WIN  = 3'h3;

    // Field positions
    localparam int WREN_BIT   = 13;
    localparam int PTR_LSB    = 8;
    localparam int ALM_EN_BIT = 15;
    localparam int CHIME_BIT  = 14;
    localparam int RPT_LSB    = 0;
    localparam int MONTH_LSB  = 8;
    localparam int MONTH_W    = 5;
    localparam int HR_TEN_LSB = 4;

    // Window pointer codes
    localparam logic [1:0] PTR_MINUTES_SECONDS_VALUE = 2'h0;
    localparam logic [1:0] PTR_WEEKDAY_HOURS_VALUE = 2'h1;
    localparam logic [1:0] PTR_MONTH_DAY_VALUE  = 2'h2;
    localparam logic [1:0] PTR_YEAR   = 2'h3;

    // Implemented bits of each value register
    localparam logic [15:0] MASK_MINUTES_SECONDS_VALUE   = 16'h7f7f;
    localparam logic [15:0] MASK_WEEKDAY_HOURS_VALUE   = 16'h073f;
    localparam logic [15:0] MASK_MONTH_DAY_VALUE    = 16'h1f3f;
    localparam logic [15:0] MASK_MONTH_DAY_VALUE_SW = 16'h003f;
    localparam logic [15:0] MASK_YEAR     = 16'h00ff;

    // Limits and values after reset
    localparam logic [1:0]  HR_TEN_MAX = 2'h2;
    localparam logic [1:0]  PTR_RST    = 2'h0;
    localparam logic [7:0]  RPT_RST    = 8'h00;
    localparam logic [7:0]  RPT_MAX    = 8'hff;
    localparam logic [15:0] RDATA_RST  = 16'h0000;

endpackage : rtv_pkg

// *** src/rtv_repeat_cnt.sv ***
`timescale 1ns/1ps
`default_nettype none

module rtv_repeat_cnt #(
    parameter int RPT_W = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    // Software load
    input  wire logic             load_in,
    input  wire logic             en_in,
    input  wire logic             chime_in,
    input  wire logic [RPT_W-1:0] cnt_in,
    // Alarm event
    input  wire logic             event_in,
    // State
    output logic                  en_out,
    output logic                  chime_out,
    output logic      [RPT_W-1:0] cnt_out
);

    logic             en_ff;
    logic             chime_ff;
    logic [RPT_W-1:0] cnt_ff;
    logic             nxt_en;
    logic             nxt_chime;
    logic [RPT_W-1:0] nxt_cnt;

    always_comb begin
        nxt_en    = en_ff;
        nxt_chime = chime_ff;
        nxt_cnt   = cnt_ff;
        if (load_in) begin
            nxt_en    = en_in;
            nxt_chime = chime_in;
            nxt_cnt   = cnt_in;
        end else if (event_in && en_ff) begin
            if (cnt_ff != '0) begin
                nxt_cnt = cnt_ff - RPT_W'(1);
            end else if (chime_ff) begin
                nxt_cnt = '1;
            end else begin
                nxt_en = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            en_ff    <= 1'b0;
            chime_ff <= 1'b0;
            cnt_ff   <= rtv_pkg::RPT_RST;
        end else begin
            en_ff    <= nxt_en;
            chime_ff <= nxt_chime;
            cnt_ff   <= nxt_cnt;
        end
    end

    assign en_out    = en_ff;
    assign chime_out = chime_ff;
    assign cnt_out   = cnt_ff;

endmodule : rtv_repeat_cnt

`default_nettype wire

// *** src/rtv_win_ptr.sv ***
`timescale 1ns/1ps
`default_nettype none

module rtv_win_ptr #(
    parameter int PTR_W = 2
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    // Control
    input  wire logic             load_in,
    input  wire logic [PTR_W-1:0] load_val_in,
    input  wire logic             access_in,
    // State
    output logic      [PTR_W-1:0] ptr_out
);

    logic [PTR_W-1:0] ptr_ff;
    logic [PTR_W-1:0] nxt_ptr;

    always_comb begin
        nxt_ptr = ptr_ff;
        if (load_in) begin
            nxt_ptr = load_val_in;
        end else if (access_in && (ptr_ff != '0)) begin
            nxt_ptr = ptr_ff - PTR_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ptr_ff <= rtv_pkg::PTR_RST;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    assign ptr_out = ptr_ff;

endmodule : rtv_win_ptr

`default_nettype wire

// *** verif/rtv_core_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module rtv_core_sva #(
    parameter int ADDR_W = 3,
    parameter int DATA_W = 16,
    parameter int RPT_W  = 8
) (
    // Clock, reset and register port
    input wire logic                        clk_in,
    input wire logic                        reset_n_in,
    input wire logic [ADDR_W-1:0]           addr_in,
    input wire logic [DATA_W-1:0]           wr_data_in,
    input wire logic                        wr_in,
    input wire logic                        rd_in,
    input wire logic [DATA_W-1:0]           rd_data_out,
    // Events and alarm state
    input wire logic                        month_update_in,
    input wire logic [rtv_pkg::MONTH_W-1:0] month_value_in,
    input wire logic                        alarm_event_in,
    input wire logic                        alarm_enable_out
);
    logic             m_en;
    logic             m_ch;
    logic [RPT_W-1:0] m_cnt;
    logic             cfg_wr;
    logic             cfg_rd;

    assign cfg_wr = wr_in && addr_in == rtv_pkg::OFS_ALM_CFG;
    assign cfg_rd = rd_in && addr_in == rtv_pkg::OFS_ALM_CFG;

    // Shadow of alarm enable, chime and repeat count
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            m_en  <= 1'b0;
            m_ch  <= 1'b0;
            m_cnt <= '0;
        end else if (cfg_wr) begin
            m_en  <= wr_data_in[rtv_pkg::ALM_EN_BIT];
            m_ch  <= wr_data_in[rtv_pkg::CHIME_BIT];
            m_cnt <= wr_data_in[RPT_W-1:0];
        end else if (alarm_event_in && m_en) begin
            if (m_cnt != '0)
                m_cnt <= m_cnt - 1'b1;
            else if (m_ch)
                m_cnt <= '1;
            else
                m_en <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_rd_idle_zero: assert property (!$past(rd_in) |-> rd_data_out == '0)
        else $error("read data not zero outside read slot");
    a_unmapped_zero: assert property (rd_in && addr_in[2] |=> rd_data_out == '0)
        else $error("unmapped read not zero");
    a_cfg_unused_zero: assert property (rd_in && addr_in == rtv_pkg::OFS_CFG
        |=> (rd_data_out & 16'hdcff) == '0) else $error("config spare bits set");
    a_time_top_zero: assert property (rd_in && addr_in == rtv_pkg::OFS_TIME_WIN
        |=> !rd_data_out[15]) else $error("time window bit 15 set");
    a_alm_unused_zero: assert property (rd_in && addr_in == rtv_pkg::OFS_ALM_WIN
        |=> (rd_data_out & 16'h8080) == '0) else $error("alarm window spare bits set");
    a_cnt_readback: assert property (cfg_rd |=> rd_data_out[RPT_W-1:0] == $past(m_cnt)
        && rd_data_out[15:14] == {$past(m_en), $past(m_ch)}) else $error("repeat count wrong");
    a_en_tracks: assert property (alarm_enable_out == m_en)
        else $error("alarm enable wrong");
    a_en_autoclear: assert property (alarm_event_in && alarm_enable_out && !cfg_wr
        && m_cnt == '0 && !m_ch |=> !alarm_enable_out) else $error("enable not cleared");
    a_wrap_to_max: assert property (alarm_event_in && m_en && !cfg_wr && m_cnt == '0
        && m_ch ##1 cfg_rd |=> rd_data_out[RPT_W-1:0] == '1) else $error("count did not wrap");
    a_en_fall_cause: assert property ($fell(alarm_enable_out)
        |-> $past(alarm_event_in) || $past(cfg_wr)) else $error("enable fell without cause");
endmodule : rtv_core_sva

bind rtv_core rtv_core_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .RPT_W(RPT_W)) u_sva (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .month_update_in(month_update_in),
    .month_value_in(month_value_in), .alarm_event_in(alarm_event_in),
    .alarm_enable_out(alarm_enable_out));

`default_nettype wire

// *** verif/rtv_core_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module rtv_core_tb_top;
    logic        clk_in;
    logic        reset_n_in;
    logic [2:0]  addr_in;
    logic [15:0] wr_data_in;
    logic        wr_in;
    logic        rd_in;
    logic [15:0] rd_data_out;
    logic        month_update_in;
    logic [4:0]  month_value_in;
    logic        alarm_event_in;
    logic        alarm_enable_out;
    int          num_errors;
    int          samples_checked;
    int          tv[4];
    int          av[4];
    int          tp, ap, wren, aen, ch, cnt, seed, r;
    logic [15:0] rdat;
    logic [15:0] acfg[4] = '{16'h8002, 16'hc001, 16'h8000, 16'hc0ff};

    rtv_core dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .month_update_in(month_update_in), .month_value_in(month_value_in),
        .alarm_event_in(alarm_event_in), .alarm_enable_out(alarm_enable_out));

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    function automatic int fix(int p, int v);
        // Hour tens of three is held as two
        if (p == 1 && ((v >> 4) & 3) == 3)
            return v & 16'hffef;
        return v;
    endfunction : fix

    function automatic int msk(int p);
        case (p)
            0: return rtv_pkg::MASK_MINUTES_SECONDS_VALUE;
            1: return rtv_pkg::MASK_WEEKDAY_HOURS_VALUE;
            2: return rtv_pkg::MASK_MONTH_DAY_VALUE;
            default: return rtv_pkg::MASK_YEAR;
        endcase
    endfunction : msk

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t read %h expected %h", $time, got, exp);
        end
    endtask : check

    // k = {month update, alarm event, read, write}
    task automatic op(input logic [3:0] k, input logic [2:0] a, input logic [15:0] d);
        int e;
        wr_in           <= k[0];
        rd_in           <= k[1];
        alarm_event_in  <= k[2];
        month_update_in <= k[3];
        addr_in         <= a;
        wr_data_in      <= d;
        month_value_in  <= d[12:8];
        @(posedge clk_in);
        case (a)
            rtv_pkg::OFS_CFG:      e = wren << 13 | tp << 8;
            rtv_pkg::OFS_ALM_CFG:  e = aen << 15 | ch << 14 | ap << 8 | cnt;
            rtv_pkg::OFS_TIME_WIN: e = tv[tp];
            rtv_pkg::OFS_ALM_WIN:  e = ap == 3 ? 0 : av[ap];
            default:               e = 0;
        endcase
        if (k[0] && a == rtv_pkg::OFS_CFG) begin
            wren = d[13];
            tp   = d[9:8];
        end
        if (k[0] && a == rtv_pkg::OFS_ALM_CFG) begin
            aen = d[15];
            ch  = d[14];
            ap  = d[9:8];
            cnt = d[7:0];
        end
        if (k[0] && wren && a == rtv_pkg::OFS_TIME_WIN)
            tv[tp] = tp == 2 ? tv[2] & 16'h1f00 | d & 16'h003f : fix(tp, d & msk(tp));
        if (k[0] && wren && a == rtv_pkg::OFS_ALM_WIN && ap != 3)
            av[ap] = fix(ap, d & msk(ap));
        if ((k[0] || k[1]) && a == rtv_pkg::OFS_TIME_WIN && tp > 0)
            tp--;
        if ((k[0] || k[1]) && a == rtv_pkg::OFS_ALM_WIN && ap > 0)
            ap--;
        if (k[2] && aen && !(k[0] && a == rtv_pkg::OFS_ALM_CFG)) begin
            if (cnt > 0)
                cnt--;
            else if (ch)
                cnt = 255;
            else
                aen = 0;
        end
        if (k[3])
            tv[2] = tv[2] & 16'h003f | d & 16'h1f00;
        if (k[1]) begin
            rd_in           <= 1'b0;
            alarm_event_in  <= 1'b0;
            month_update_in <= 1'b0;
            #1 check(rd_data_out, e[15:0]);
            check({15'h0000, alarm_enable_out}, 16'(aen));
            @(posedge clk_in);
        end
    endtask : op

    task automatic finish_test;
        $display("Errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    initial begin
        {reset_n_in, wr_in, rd_in, month_update_in, alarm_event_in} = 5'h00;
        addr_in = 3'h0;
        wr_data_in = 16'h0000;
        month_value_in = 5'h00;
        {num_errors, samples_checked, tp, ap, wren, aen, ch, cnt} = '0;
        seed = $urandom(54);
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        op(4'h2, rtv_pkg::OFS_CFG, 16'h0000);
        op(4'h2, rtv_pkg::OFS_ALM_CFG, 16'h0000);
        op(4'h8, rtv_pkg::OFS_CFG, 16'h1200);
        for (int i = 0; i < 2; i++) begin
            op(4'h1, rtv_pkg::OFS_CFG, i ? 16'h0300 : 16'h2300);
            repeat (5) op(4'h1, rtv_pkg::OFS_TIME_WIN, 16'($urandom));
            op(4'h1, rtv_pkg::OFS_ALM_CFG, 16'h0300);
            repeat (5) op(4'h1, rtv_pkg::OFS_ALM_WIN, 16'($urandom));
            op(4'h1, rtv_pkg::OFS_CFG, 16'h0300);
            repeat (5) op(4'h2, rtv_pkg::OFS_TIME_WIN, 16'h0000);
            op(4'h1, rtv_pkg::OFS_ALM_CFG, 16'h0300);
            repeat (5) op(4'h2, rtv_pkg::OFS_ALM_WIN, 16'h0000);
        end
        foreach (acfg[i]) begin
            op(4'h1, rtv_pkg::OFS_ALM_CFG, acfg[i]);
            repeat (3) begin
                op(4'h4, rtv_pkg::OFS_CFG, 16'h0000);
                op(4'h2, rtv_pkg::OFS_ALM_CFG, 16'h0000);
            end
        end
        op(4'h5, rtv_pkg::OFS_ALM_CFG, 16'h8005);
        op(4'h2, rtv_pkg::OFS_ALM_CFG, 16'h0000);
        for (int a = 4; a < 8; a++) begin
            op(4'h1, 3'(a), 16'hffff);
            op(4'h2, 3'(a), 16'h0000);
        end
        repeat (300) begin
            r    = $urandom;
            rdat = 16'($urandom);
            if (3'(r) == rtv_pkg::OFS_ALM_CFG)
                rdat = rdat & 16'hc3ff;
            op({r[8] & r[9], r[10] & r[11], r[3], ~r[3]}, 3'(r), rdat);
        end
        finish_test;
    end

    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test;
    end
endmodule : rtv_core_tb_top

`default_nettype wire
